// ===== src/ldie_exec.sv
// Executor for the loop-decrement branch, byte increment and data pointer increment.
// Assumes an asynchronous-read operand store: rd_data is valid in the cycle rd_en is high.
`timescale 1ns/1ps

module ldie_exec
    import ldie_pkg::*;
#(
    parameter logic [7:0] OP_DECREMENT_BRANCH_NONZERO_DIR = 8'hD5
)
(
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        issue,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  byte2,
    input  wire logic [7:0]  byte3,
    input  wire logic [15:0] pc_in,
    input  wire logic [7:0]  acc_in,
    input  wire logic [15:0] data_pointer16_in,
    input  wire logic [7:0]  rd_data,
    output logic             busy_r,
    output logic             done_r,
    output logic             illegal_r,
    output logic             rd_en_r,
    output logic [1:0]       rd_space_r,
    output logic [7:0]       rd_addr_r,
    output logic             rd_latch_r,
    output logic             wr_en_r,
    output logic [1:0]       wr_space_r,
    output logic [7:0]       wr_addr_r,
    output logic [7:0]       wr_data_r,
    output logic             acc_we_r,
    output logic [7:0]       acc_wdata_r,
    output logic             data_pointer16_we_r,
    output logic [15:0]      data_pointer16_wdata_r,
    output logic             pc_we_r,
    output logic [15:0]      pc_wdata_r
);

    // ==========================================================
    // Decode
    ldie_state_t state_r;
    ldie_state_t state_nxt;
    logic [7:0]  op_r;
    logic [7:0]  b2_r;
    logic [7:0]  b3_r;
    logic [15:0] pc_r;
    logic [15:0] len_r;
    logic [3:0]  cyc_r;
    logic [3:0]  cnt_r;
    logic [7:0]  opnd_r;
    logic [7:0]  res_r;
    logic [1:0]  tgt_space_r;
    logic [7:0]  tgt_addr_r;

    wire         st_idle     = (state_r == ST_IDLE);
    wire         issue_ok    = issue && st_idle;
    wire [7:0]   dec_op      = st_idle ? opcode : op_r;
    wire         f_decrement_branch_nonzero_rn   = (dec_op[7:3] == OP_DECREMENT_BRANCH_NONZERO_RN_HI);
    wire         f_decrement_branch_nonzero_dir  = (dec_op == OP_DECREMENT_BRANCH_NONZERO_DIR);
    wire         f_inc_acc   = (dec_op == OP_INC_ACC);
    wire         f_inc_rn    = (dec_op[7:3] == OP_INC_RN_HI);
    wire         f_inc_dir   = (dec_op == OP_INC_DIR);
    wire         f_inc_ind   = (dec_op[7:1] == OP_INC_IND_HI);
    wire         f_inc_data_pointer16  = (dec_op == OP_INC_DATA_POINTER16);
    wire         f_decrement_branch_nonzero      = f_decrement_branch_nonzero_rn || f_decrement_branch_nonzero_dir;
    wire         f_legal     = f_decrement_branch_nonzero || f_inc_acc || f_inc_rn || f_inc_dir || f_inc_ind
                               || f_inc_data_pointer16;
    wire         f_direct    = f_decrement_branch_nonzero_dir || f_inc_dir;
    wire [3:0]   op_cycles   = (f_decrement_branch_nonzero || f_inc_data_pointer16) ? CYC_TWO : CYC_ONE;
    wire [15:0]  op_len      = f_decrement_branch_nonzero_dir ? LEN_THREE :
                               (f_decrement_branch_nonzero_rn || f_inc_dir) ? LEN_TWO : LEN_ONE;
    wire [1:0]   first_space = f_direct ? SP_DIR : SP_REG;
    wire [7:0]   first_addr  = f_inc_ind ? {7'h00, opcode[0]} :
                               f_direct ? byte2 : {5'h00, opcode[2:0]};

    // ==========================================================
    // Arithmetic
    wire [7:0]   opnd_src    = f_inc_acc ? acc_in : opnd_r;
    wire [7:0]   res_val     = f_decrement_branch_nonzero ? 8'(opnd_src - 8'h01) : 8'(opnd_src + 8'h01);
    wire [15:0]  data_pointer16_inc    = 16'(data_pointer16_in + 16'h0001);
    wire [7:0]   rel         = f_decrement_branch_nonzero_rn ? b2_r : b3_r;
    wire [15:0]  seq_pc      = 16'(pc_r + len_r);
    wire [15:0]  tgt_pc      = 16'(seq_pc + {{8{rel[7]}}, rel});
    wire         taken       = f_decrement_branch_nonzero && (res_r != BYTE_RST);
    wire         finish      = (cnt_r == 4'(cyc_r - 4'h1));
    wire         in_write    = (state_r == ST_WRITE);
    wire         ending      = (in_write || state_r == ST_WAIT) && finish;
    wire         op_decrement_branch_nonzero     = (op_r[7:3] == OP_DECREMENT_BRANCH_NONZERO_RN_HI) || (op_r == OP_DECREMENT_BRANCH_NONZERO_DIR);

    // ==========================================================
    // Sequencer
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:
            begin
                if (issue)
                begin
                    if (!f_legal)
                        state_nxt = ST_WAIT;
                    else if (f_inc_acc || f_inc_data_pointer16)
                        state_nxt = ST_WRITE;
                    else if (f_inc_ind)
                        state_nxt = ST_PTR;
                    else
                        state_nxt = ST_READ;
                end
            end
            ST_PTR:   state_nxt = ST_READ;
            ST_READ:  state_nxt = ST_WRITE;
            ST_WRITE: state_nxt = finish ? ST_IDLE : ST_WAIT;
            ST_WAIT:  state_nxt = finish ? ST_IDLE : ST_WAIT;
            default:  state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_r <= ST_IDLE;
            cnt_r   <= CNT_START;
            busy_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= st_idle ? CNT_START : 4'(cnt_r + 4'h1);
            busy_r  <= (state_nxt != ST_IDLE);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            op_r  <= BYTE_RST;
            b2_r  <= BYTE_RST;
            b3_r  <= BYTE_RST;
            pc_r  <= WORD_RST;
            len_r <= LEN_ONE;
            cyc_r <= CYC_ONE;
        end
        else if (issue_ok)
        begin
            op_r  <= opcode;
            b2_r  <= byte2;
            b3_r  <= byte3;
            pc_r  <= pc_in;
            len_r <= f_legal ? op_len : LEN_ONE;
            cyc_r <= f_legal ? op_cycles : CYC_ONE;
        end
    end

    // ==========================================================
    // Operand read and write-back
    // The latch select is held high on every read: all reads here except the indirect pointer fetch are read-modify-write.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            rd_en_r     <= 1'b0;
            rd_space_r  <= SP_REG;
            rd_addr_r   <= BYTE_RST;
            rd_latch_r  <= 1'b0;
            tgt_space_r <= SP_REG;
            tgt_addr_r  <= BYTE_RST;
            opnd_r      <= BYTE_RST;
        end
        else
        begin
            rd_en_r    <= (issue_ok && f_legal && !f_inc_acc && !f_inc_data_pointer16)
                          || (state_r == ST_PTR);
            rd_latch_r <= (issue_ok && f_legal && !f_inc_acc && !f_inc_data_pointer16)
                          || (state_r == ST_PTR);
            if (issue_ok)
            begin
                rd_space_r  <= first_space;
                rd_addr_r   <= first_addr;
                tgt_space_r <= first_space;
                tgt_addr_r  <= first_addr;
            end
            else if (state_r == ST_PTR)
            begin
                rd_space_r  <= SP_IND;
                rd_addr_r   <= rd_data;
                tgt_space_r <= SP_IND;
                tgt_addr_r  <= rd_data;
            end
            if (state_r == ST_READ)
                opnd_r <= rd_data;
        end
    end

    // Flags never appear here: no path exists that could alter them.
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            wr_en_r      <= 1'b0;
            wr_space_r   <= SP_REG;
            wr_addr_r    <= BYTE_RST;
            wr_data_r    <= BYTE_RST;
            acc_we_r     <= 1'b0;
            acc_wdata_r  <= BYTE_RST;
            data_pointer16_we_r    <= 1'b0;
            data_pointer16_wdata_r <= WORD_RST;
            res_r        <= BYTE_RST;
        end
        else
        begin
            wr_en_r   <= in_write && !f_inc_acc && !f_inc_data_pointer16;
            acc_we_r  <= in_write && f_inc_acc;
            data_pointer16_we_r <= in_write && f_inc_data_pointer16;
            if (in_write)
            begin
                wr_space_r   <= tgt_space_r;
                wr_addr_r    <= tgt_addr_r;
                wr_data_r    <= res_val;
                acc_wdata_r  <= res_val;
                data_pointer16_wdata_r <= data_pointer16_inc;
                res_r        <= res_val;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            done_r     <= 1'b0;
            illegal_r  <= 1'b0;
            pc_we_r    <= 1'b0;
            pc_wdata_r <= WORD_RST;
        end
        else
        begin
            done_r    <= ending;
            pc_we_r   <= ending;
            illegal_r <= ending && !f_legal;
            if (ending)
                pc_wdata_r <= taken ? tgt_pc : seq_pc;
        end
    end

    // ==========================================================
    // Assertions
    property p_branch_target;
        @(posedge clk_sys) disable iff (sys_rst)
        (pc_we_r && op_decrement_branch_nonzero) |->
            (pc_wdata_r == ((res_r != 8'h00) ? tgt_pc : seq_pc));
    endproperty
    a_branch_target: assert property (p_branch_target) else $error("loop branch target wrong");

    property p_decrement_branch_nonzero_rn_time;
        @(posedge clk_sys) disable iff (sys_rst)
        (issue_ok && opcode[7:3] == 5'h1B) |-> ##1 !done_r [*7] ##1 done_r;
    endproperty
    a_decrement_branch_nonzero_rn_time: assert property (p_decrement_branch_nonzero_rn_time) else $error("register loop not 8 clocks");

    property p_inc_dir_time;
        @(posedge clk_sys) disable iff (sys_rst)
        (issue_ok && opcode == 8'h05) |-> ##4 (done_r && pc_wdata_r == $past(pc_in, 4) + 16'h2);
    endproperty
    a_inc_dir_time: assert property (p_inc_dir_time) else $error("direct increment timing");

    property p_data_pointer16_time;
        @(posedge clk_sys) disable iff (sys_rst)
        (issue_ok && opcode == 8'hA3) |-> ##2 data_pointer16_we_r ##6 (done_r && !data_pointer16_we_r);
    endproperty
    a_data_pointer16_time: assert property (p_data_pointer16_time) else $error("pointer increment timing");

    property p_data_pointer16_only;
        @(posedge clk_sys) disable iff (sys_rst)
        data_pointer16_we_r |-> (op_r == 8'hA3 && !wr_en_r && !acc_we_r);
    endproperty
    a_data_pointer16_only: assert property (p_data_pointer16_only) else $error("16-bit write from wrong op");

    property p_latch_read;
        @(posedge clk_sys) disable iff (sys_rst)
        rd_en_r |-> rd_latch_r;
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("read not from latch");

    property p_inc_value;
        @(posedge clk_sys) disable iff (sys_rst)
        (wr_en_r && !op_decrement_branch_nonzero) |-> (wr_data_r == 8'(opnd_r + 8'h01));
    endproperty
    a_inc_value: assert property (p_inc_value) else $error("increment value wrong");

    property p_dec_value;
        @(posedge clk_sys) disable iff (sys_rst)
        (wr_en_r && op_decrement_branch_nonzero) |-> (wr_data_r == 8'(opnd_r - 8'h01) && wr_space_r != 2'h2);
    endproperty
    a_dec_value: assert property (p_dec_value) else $error("loop decrement wrong");

    property p_ptr_select;
        @(posedge clk_sys) disable iff (sys_rst)
        (issue_ok && opcode[7:1] == 7'h03) |->
            ##1 (rd_en_r && rd_addr_r == {7'h00, $past(opcode[0])}) ##1 (rd_space_r == 2'h2);
    endproperty
    a_ptr_select: assert property (p_ptr_select) else $error("pointer select wrong");

    c_taken:   cover property (@(posedge clk_sys) pc_we_r && op_decrement_branch_nonzero && res_r != 8'h00);
    c_fall:    cover property (@(posedge clk_sys) pc_we_r && op_decrement_branch_nonzero && res_r == 8'h00);
    c_ind_inc: cover property (@(posedge clk_sys) wr_en_r && wr_space_r == 2'h2);
    c_data_pointer16:    cover property (@(posedge clk_sys) data_pointer16_we_r && data_pointer16_in[7:0] == 8'hFF);

endmodule

// ===== src/ldie_pkg.sv
// Constants, opcode patterns and state encoding for the loop, decrement and increment executor.
// Assumes one machine cycle spans a fixed number of core clocks on the single machine clock.
// Function
// - Loop instruction subtracts one, writes back, branches only when the result is nonzero.
// - Register loop form is 11011rrr plus offset byte; two bytes, two machine cycles.
// - Program counter first advances past the instruction; taken branch adds offset to it.
// - One loop instruction delays from 2 to 512 machine cycles, two per pass.
// - Port operands for loop and increment come from the output latch, not pins.
// - Byte increment adds one modulo 256, FF wraps to 00, flags untouched.
// - Byte increment works on working register, direct byte, indirect byte and accumulator.
// - Direct increment is 00000101 plus address byte; two bytes, one machine cycle.
// - Pointer increment is a 16-bit add of one; low byte carries into high byte.
// - Only the 16-bit data pointer has a 16-bit increment path.
// - Loop offset is a signed byte, the last byte, added to the advanced counter.
// - Loop operand zero wraps to FF; register or direct operand only; flags untouched.
package ldie_pkg;

    // ==========================================================
    // Opcode patterns
    localparam logic [7:0] OP_INC_ACC    = 8'h04;
    localparam logic [7:0] OP_INC_DIR    = 8'h05;
    localparam logic [7:0] OP_INC_DATA_POINTER16   = 8'hA3;
    localparam logic [4:0] OP_DECREMENT_BRANCH_NONZERO_RN_HI = 5'h1B;
    localparam logic [4:0] OP_INC_RN_HI  = 5'h01;
    localparam logic [6:0] OP_INC_IND_HI = 7'h03;

    // ==========================================================
    // Timing and lengths
    localparam logic [3:0]  CLK_PER_MC = 4'h4;
    localparam logic [3:0]  CYC_ONE    = CLK_PER_MC;
    localparam logic [3:0]  CYC_TWO    = 4'(CLK_PER_MC * 4'h2);
    localparam logic [3:0]  CNT_START  = 4'h1;
    localparam logic [15:0] LEN_ONE    = 16'h0001;
    localparam logic [15:0] LEN_TWO    = 16'h0002;
    localparam logic [15:0] LEN_THREE  = 16'h0003;

    // ==========================================================
    // Operand spaces and reset values
    localparam logic [1:0]  SP_REG     = 2'h0;
    localparam logic [1:0]  SP_DIR     = 2'h1;
    localparam logic [1:0]  SP_IND     = 2'h2;
    localparam logic [7:0]  BYTE_RST   = 8'h00;
    localparam logic [15:0] WORD_RST   = 16'h0000;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_PTR   = 5'h02,
        ST_READ  = 5'h04,
        ST_WRITE = 5'h08,
        ST_WAIT  = 5'h10
    } ldie_state_t;

endpackage

// ===== testbench/ldie_exec_bench.sv
// Self-checking bench for the loop, decrement and increment executor.
// Assumes the executor alone; the bench plays the issuing stage and the operand store.
`timescale 1ns/1ps

module ldie_exec_bench
    import ldie_pkg::*;
;
    // ==========================================================
    // Signals and operand store
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        issue   = 1'b0;
    logic [7:0]  opcode  = 8'h00;
    logic [7:0]  byte2   = 8'h00;
    logic [7:0]  byte3   = 8'h00;
    logic [7:0]  acc_in  = 8'h00;
    logic [15:0] pc_in   = 16'h0000;
    logic [15:0] data_pointer16_in = 16'h0000;
    wire  [7:0]  rd_data;
    logic        busy_r, done_r, illegal_r, rd_en_r, rd_latch_r, wr_en_r;
    logic        acc_we_r, data_pointer16_we_r, pc_we_r, ill, bad_latch;
    logic [1:0]  rd_space_r, wr_space_r, w_space;
    logic [7:0]  rd_addr_r, wr_addr_r, wr_data_r, acc_wdata_r, w_addr, w_data, acc_d;
    logic [7:0]  n_wr, n_acc, n_data_pointer16, n_cyc;
    logic [15:0] data_pointer16_wdata_r, pc_wdata_r, data_pointer16_d, pc_d;
    logic [7:0]  mem [0:1023];
    int          miscompares = 0;
    int          cmp_count   = 0;
    int          cyc         = 0;

    // The direct loop encoding is a design parameter; the bench uses its default.
    localparam logic [7:0] OP_DECREMENT_BRANCH_NONZERO_DIR_V = 8'hD5;

    // An idle read bus shows a fixed pattern so a late read cannot pass by luck.
    assign rd_data = (rd_en_r === 1'b1) ? mem[{rd_space_r, rd_addr_r}] : 8'h5A;

    ldie_exec u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .issue(issue), .opcode(opcode),
        .byte2(byte2), .byte3(byte3), .pc_in(pc_in), .acc_in(acc_in), .data_pointer16_in(data_pointer16_in),
        .rd_data(rd_data), .busy_r(busy_r), .done_r(done_r), .illegal_r(illegal_r),
        .rd_en_r(rd_en_r), .rd_space_r(rd_space_r), .rd_addr_r(rd_addr_r),
        .rd_latch_r(rd_latch_r), .wr_en_r(wr_en_r), .wr_space_r(wr_space_r),
        .wr_addr_r(wr_addr_r), .wr_data_r(wr_data_r), .acc_we_r(acc_we_r),
        .acc_wdata_r(acc_wdata_r), .data_pointer16_we_r(data_pointer16_we_r), .data_pointer16_wdata_r(data_pointer16_wdata_r),
        .pc_we_r(pc_we_r), .pc_wdata_r(pc_wdata_r));

    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Entered just after a rising edge; returns at the edge that ends the done cycle.
    // With poke set, a second request is raised while busy and must be ignored.
    task automatic run(input logic [7:0] op, b2, b3, input logic [15:0] pc, input bit poke);
        int n;
        n = 0;
        n_wr = 8'h00;
        n_acc = 8'h00;
        n_data_pointer16 = 8'h00;
        ill = 1'b0;
        bad_latch = 1'b0;
        issue <= 1'b1;
        opcode <= op;
        byte2 <= b2;
        byte3 <= b3;
        pc_in <= pc;
        @(posedge clk_sys);
        issue <= 1'b0;
        while (done_r !== 1'b1 && n < 40)
        begin
            @(negedge clk_sys);
            n++;
            if (n == 1)
                chk(busy_r, 1'b1);
            if (rd_en_r === 1'b1 && rd_latch_r !== 1'b1)
                bad_latch = 1'b1;
            if (wr_en_r === 1'b1)
            begin
                n_wr++;
                w_data = wr_data_r;
                w_addr = wr_addr_r;
                w_space = wr_space_r;
            end
            if (acc_we_r === 1'b1)
            begin
                n_acc++;
                acc_d = acc_wdata_r;
            end
            if (data_pointer16_we_r === 1'b1)
            begin
                n_data_pointer16++;
                data_pointer16_d = data_pointer16_wdata_r;
            end
            if (pc_we_r === 1'b1)
                pc_d = pc_wdata_r;
            if (illegal_r === 1'b1)
                ill = 1'b1;
            if (poke && n == 2)
            begin
                @(posedge clk_sys);
                issue <= 1'b1;
                opcode <= OP_INC_ACC;
                @(posedge clk_sys);
                issue <= 1'b0;
                n++;
            end
        end
        n_cyc = 8'(n);
        @(posedge clk_sys);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_loop_reg();
        mem[3] = 8'h05;
        run({OP_DECREMENT_BRANCH_NONZERO_RN_HI, 3'h3}, 8'hF0, 8'h00, 16'h1000, 1'b0);
        chk(w_data, 8'h04);
        chk({w_space, w_addr}, {SP_REG, 8'h03});
        chk(n_cyc, CYC_TWO);
        chk(pc_d, 16'h0FF2);
        mem[1] = 8'h01;
        run({OP_DECREMENT_BRANCH_NONZERO_RN_HI, 3'h1}, 8'h7F, 8'h00, 16'h2000, 1'b0);
        chk({w_data, pc_d}, {8'h00, 16'h2002});
        mem[7] = 8'h00;
        run({OP_DECREMENT_BRANCH_NONZERO_RN_HI, 3'h7}, 8'h10, 8'h00, 16'h3000, 1'b0);
        chk({w_data, pc_d}, {8'hFF, 16'h3012});
        chk({n_cyc, n_acc, n_data_pointer16}, {4'h0, CYC_TWO, 16'h0000});
    endtask

    task automatic t_loop_dir();
        mem[10'h140] = 8'h70;
        run(OP_DECREMENT_BRANCH_NONZERO_DIR_V, 8'h40, 8'h05, 16'h4000, 1'b0);
        chk({w_space, w_addr, w_data}, {SP_DIR, 8'h40, 8'h6F});
        chk(pc_d, 16'h4008);
        chk(bad_latch, 1'b0);
    endtask

    task automatic t_inc_byte();
        mem[10'h190] = 8'hFF;
        run(OP_INC_DIR, 8'h90, 8'h00, 16'h5000, 1'b0);
        chk({w_space, w_addr, w_data}, {SP_DIR, 8'h90, 8'h00});
        chk({n_cyc, pc_d}, {4'h0, CYC_ONE, 16'h5002});
        chk({n_acc, n_data_pointer16, bad_latch}, 17'h0);
        mem[5] = 8'h7E;
        run({OP_INC_RN_HI, 3'h5}, 8'h00, 8'h00, 16'h5100, 1'b0);
        chk({w_space, w_addr, w_data, pc_d}, {SP_REG, 8'h05, 8'h7F, 16'h5101});
        acc_in <= 8'hFF;
        run(OP_INC_ACC, 8'h00, 8'h00, 16'h5200, 1'b0);
        chk({n_acc, acc_d, n_wr, n_cyc}, {8'h01, 8'h00, 8'h00, 4'h0, CYC_ONE});
    endtask

    task automatic t_inc_ind();
        for (int i = 0; i < 2; i++)
        begin
            mem[i] = 8'h7E + 8'(i);
            mem[10'h27E + 10'(i)] = (i == 0) ? 8'hFF : 8'h40;
            run({OP_INC_IND_HI, 1'(i)}, 8'h00, 8'h00, 16'h6000, 1'b0);
            chk({w_space, w_addr}, {SP_IND, 8'h7E + 8'(i)});
            chk(w_data, (i == 0) ? 8'h00 : 8'h41);
            chk({n_cyc, pc_d}, {4'h0, CYC_ONE, 16'h6001});
        end
    endtask

    task automatic t_inc_ptr();
        data_pointer16_in <= 16'h12FF;
        run(OP_INC_DATA_POINTER16, 8'h00, 8'h00, 16'h7000, 1'b1);
        chk({n_data_pointer16, data_pointer16_d}, {8'h01, 16'h1300});
        chk({n_cyc, pc_d, n_acc}, {4'h0, CYC_TWO, 16'h7001, 8'h00});
        data_pointer16_in <= 16'hFFFF;
        run(OP_INC_DATA_POINTER16, 8'h00, 8'h00, 16'h7100, 1'b0);
        chk({n_data_pointer16, data_pointer16_d, n_wr}, {8'h01, 16'h0000, 8'h00});
    endtask

    task automatic t_illegal();
        run(8'h00, 8'h00, 8'h00, 16'h8000, 1'b0);
        chk({ill, n_wr, n_acc, n_data_pointer16}, 25'h1000000);
        chk({n_cyc, pc_d}, {4'h0, CYC_ONE, 16'h8001});
    endtask

    // ==========================================================
    // Main sequence and hang guard
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            miscompares++;
            summarize();
        end
    end

    initial
    begin
        foreach (mem[k])
            mem[k] = 8'h00;
        @(posedge clk_sys);
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(negedge clk_sys);
        chk({busy_r, done_r, wr_en_r, pc_we_r, data_pointer16_we_r}, 5'h00);
        @(posedge clk_sys);
        t_loop_reg();
        t_loop_dir();
        t_inc_byte();
        t_inc_ind();
        t_inc_ptr();
        t_illegal();
        summarize();
    end
endmodule
